// file: hdl/ctim_timer.sv
// How it works
// RULE1: software changes output function only while off
// RULE2: initial level or pwm active level bit
// RULE3: polarity bit inverts output, not timer mode
// RULE4: swap bit exchanges period and duty roles
// RULE5: clear source picks compare or period match
// RULE6: period zero means clear by overflow
// RULE7: pwm ignores clear source; period comparator clears
// RULE8: counter readable as low and high bytes
// RULE9: compare value two bytes, reset zero
// RULE10: mode 00 compare, 10 pwm, 11 timer
// RULE11: compare mode raises both match flags
// RULE12: compare clear never raises period flag
// RULE13: zero compare with compare clear overflows silently
// RULE14: output changes only on compare match
// RULE15: timer_on rise loads initial output level
// RULE16: timer mode counts like compare, no output
// RULE17: pwm raises both flags on matches
// RULE18: swap off: period 128 steps, duty compare
// RULE19: swap on: compare period, duty 128 steps
// RULE20: duty at least period gives full active
// RULE21: forced output keeps internal pwm running
// RULE22: compare codes none, low, high, toggle
// RULE23: pwm codes inactive, active, waveform
// RULE24: timer_on rise clears counter, fall holds
// RULE25: period compares counter bits 9 to 7
// RULE26: counter increments each clock, wraps 3FF
module ctim_timer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic timer_output
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0] counter;
    logic [2:0] period_value;
    logic timer_on;
    logic [1:0] mode_sel;
    logic [1:0] output_function_sel;
    logic output_initial_level;
    logic output_polarity_invert;
    logic duty_period_swap;
    logic counter_clear_source;
    logic [9:0] compare_value;
    logic compare_match_flag;
    logic period_match_flag;
    logic out_level;
    logic pin_level;
    logic waitreq;
    logic [31:0] rdata;
  } ctim_state_type;

  ctim_state_type st_r;
  ctim_state_type st_nxt;
  logic [10:0] inc;
  logic [10:0] per_len;
  logic [10:0] duty_len;
  logic a_hit;
  logic p_hit;
  logic is_pwm;
  logic clr_hit;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_word(input ctim_state_type s, input logic [4:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == ctim_pkg::OFS_CTRL0) begin
      w[ctim_pkg::ON_BIT] = s.timer_on;
      w[ctim_pkg::PER_LSB +: 3] = s.period_value;
    end else if (a == ctim_pkg::OFS_CTRL1) begin
      w[7:0] = {s.mode_sel, s.output_function_sel, s.output_initial_level,
                s.output_polarity_invert, s.duty_period_swap, s.counter_clear_source};
    end else if (a == ctim_pkg::OFS_CNT_LO) begin
      w[7:0] = s.counter[7:0]; // RULE8
    end else if (a == ctim_pkg::OFS_CNT_HI) begin
      w[1:0] = s.counter[9:8]; // RULE8
    end else if (a == ctim_pkg::OFS_CMP_LO) begin
      w[7:0] = s.compare_value[7:0];
    end else if (a == ctim_pkg::OFS_CMP_HI) begin
      w[1:0] = s.compare_value[9:8];
    end else if (a == ctim_pkg::OFS_STATUS) begin
      w[ctim_pkg::FA_BIT] = s.compare_match_flag;
      w[ctim_pkg::FP_BIT] = s.period_match_flag;
      w[ctim_pkg::OUT_BIT] = s.pin_level;
    end
    return w;
  endfunction

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  // matches look at the value the counter is about to reach, so the
  // clear lands in place of that value and the period is exact
  assign inc = {1'b0, st_r.counter} + 11'h001;
  assign is_pwm = (st_r.mode_sel == ctim_pkg::MODE_PWM); // RULE10
  // zero compare never matches; with compare clear the counter just overflows
  assign a_hit = (st_r.compare_value != ctim_pkg::RST_COMPARE) &&
                 (inc == {1'b0, st_r.compare_value}); // RULE13
  // period zero stands for 1024, which is the overflow itself
  assign per_len = (st_r.period_value == ctim_pkg::RST_PERIOD) ? ctim_pkg::FULL_SCALE :
                   {1'b0, st_r.period_value, ctim_pkg::PERIOD_LOW_ZERO}; // RULE6
  assign p_hit = (inc[10:7] == per_len[10:7]) &&
                 (inc[6:0] == ctim_pkg::PERIOD_LOW_ZERO); // RULE25
  // pwm takes its clear from the period role, others from the bit
  assign clr_hit = is_pwm ? (st_r.duty_period_swap ? a_hit : p_hit) // RULE7 RULE4
                          : (st_r.counter_clear_source ? a_hit : p_hit); // RULE5
  assign duty_len = st_r.duty_period_swap ? per_len :
                    {1'b0, st_r.compare_value}; // RULE18 RULE19

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic pwm_active;
    logic pwm_level;
    pwm_active = 1'b0;
    pwm_level = 1'b0;
    st_nxt = st_r;
    // bus slave: one wait cycle, then the request is taken
    st_nxt.waitreq = 1'b1;
    if ((avs_read || avs_write) && st_r.waitreq) begin
      st_nxt.waitreq = 1'b0;
      st_nxt.rdata = read_word(st_r, avs_address);
    end
    if (avs_write && !st_r.waitreq && avs_byteenable[0]) begin
      if (avs_address == ctim_pkg::OFS_CTRL0) begin
        st_nxt.timer_on = avs_writedata[ctim_pkg::ON_BIT];
        st_nxt.period_value = avs_writedata[ctim_pkg::PER_LSB +: 3];
      end else if (avs_address == ctim_pkg::OFS_CTRL1) begin
        // mode and output function are trusted to change only while off
        st_nxt.mode_sel = avs_writedata[ctim_pkg::MODE_LSB +: 2]; // RULE1
        st_nxt.output_function_sel = avs_writedata[ctim_pkg::IOSEL_LSB +: 2];
        st_nxt.output_initial_level = avs_writedata[ctim_pkg::OC_BIT];
        st_nxt.output_polarity_invert = avs_writedata[ctim_pkg::POL_BIT];
        st_nxt.duty_period_swap = avs_writedata[ctim_pkg::DPX_BIT];
        st_nxt.counter_clear_source = avs_writedata[ctim_pkg::CCLR_BIT];
      end else if (avs_address == ctim_pkg::OFS_CMP_LO) begin
        st_nxt.compare_value[7:0] = avs_writedata[7:0]; // RULE9
      end else if (avs_address == ctim_pkg::OFS_CMP_HI) begin
        st_nxt.compare_value[9:8] = avs_writedata[1:0]; // RULE9
      end else if (avs_address == ctim_pkg::OFS_STATUS) begin
        // write one to clear; a match in the same cycle wins below
        if (avs_writedata[ctim_pkg::FA_BIT]) begin
          st_nxt.compare_match_flag = 1'b0;
        end
        if (avs_writedata[ctim_pkg::FP_BIT]) begin
          st_nxt.period_match_flag = 1'b0;
        end
      end
    end
    // counting; the off state freezes the residual value
    if (st_r.timer_on) begin
      st_nxt.counter = clr_hit ? ctim_pkg::RST_COUNT : inc[9:0]; // RULE26 RULE24
      if (a_hit) begin
        st_nxt.compare_match_flag = 1'b1; // RULE11 RULE17
      end
      if (p_hit && (is_pwm || !st_r.counter_clear_source)) begin
        st_nxt.period_match_flag = 1'b1; // RULE11 RULE12 RULE17
      end
      if (!is_pwm && a_hit) begin
        case (st_r.output_function_sel) // RULE14 RULE22
          ctim_pkg::IO_LOW: st_nxt.out_level = 1'b0;
          ctim_pkg::IO_HIGH: st_nxt.out_level = 1'b1;
          ctim_pkg::IO_TOGGLE: st_nxt.out_level = !st_r.out_level;
          default: st_nxt.out_level = st_r.out_level;
        endcase
      end
    end
    // switching on restarts the count and the output
    if (avs_write && !st_r.waitreq && avs_byteenable[0] &&
        avs_address == ctim_pkg::OFS_CTRL0 &&
        avs_writedata[ctim_pkg::ON_BIT] && !st_r.timer_on) begin
      st_nxt.counter = ctim_pkg::RST_COUNT; // RULE24
      st_nxt.out_level = st_r.output_initial_level; // RULE15 RULE2
    end
    // pwm keeps counting whatever the output function forces
    pwm_active = ({1'b0, st_nxt.counter} < duty_len); // RULE20 RULE21
    case (st_r.output_function_sel) // RULE23
      ctim_pkg::IO_ACTIVE: pwm_level = st_r.output_initial_level;
      ctim_pkg::IO_PWM: pwm_level = pwm_active ? st_r.output_initial_level
                                              : !st_r.output_initial_level; // RULE2
      default: pwm_level = !st_r.output_initial_level;
    endcase
    // timer/counter mode leaves the pin parked low
    if (st_r.mode_sel == ctim_pkg::MODE_TC) begin
      st_nxt.pin_level = 1'b0; // RULE16
    end else begin
      st_nxt.pin_level = (is_pwm ? pwm_level : st_nxt.out_level) ^
                         st_r.output_polarity_invert; // RULE3
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.waitreq <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.waitreq;
  assign timer_output = st_r.pin_level;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_on_clear;
    !st_r.timer_on ##1 st_r.timer_on |-> st_r.counter == 10'h000;
  endproperty
  a_on_clear: assert property (p_on_clear) else $error("counter not cleared on start"); // RULE24

  property p_off_hold;
    !st_r.timer_on ##1 !st_r.timer_on |-> $stable(st_r.counter);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("counter moved while off"); // RULE24

  property p_count_step;
    st_r.timer_on && !clr_hit ##1 st_r.timer_on |-> st_r.counter == $past(inc[9:0]);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step"); // RULE26

  property p_clear_wrap;
    st_r.timer_on && clr_hit && !avs_write |=> st_r.counter == 10'h000;
  endproperty
  a_clear_wrap: assert property (p_clear_wrap) else $error("no clear on match"); // RULE5

  property p_fa_set;
    st_r.timer_on && a_hit |=> st_r.compare_match_flag;
  endproperty
  a_fa_set: assert property (p_fa_set) else $error("compare flag missed"); // RULE11

  property p_fp_set;
    st_r.timer_on && p_hit && (is_pwm || !st_r.counter_clear_source)
      |=> st_r.period_match_flag;
  endproperty
  a_fp_set: assert property (p_fp_set) else $error("period flag missed"); // RULE17

  property p_fp_quiet;
    (!is_pwm && st_r.counter_clear_source && !st_r.period_match_flag && !avs_write)
      |=> !st_r.period_match_flag;
  endproperty
  a_fp_quiet: assert property (p_fp_quiet) else $error("period flag raised"); // RULE12

  property p_tc_pin;
    st_r.mode_sel == ctim_pkg::MODE_TC |=> !timer_output;
  endproperty
  a_tc_pin: assert property (p_tc_pin) else $error("pin driven in timer mode"); // RULE16

  property p_cmp_high;
    st_r.timer_on && !is_pwm && st_r.mode_sel != ctim_pkg::MODE_TC && a_hit &&
      st_r.output_function_sel == ctim_pkg::IO_HIGH && !avs_write
      |=> timer_output == !$past(st_r.output_polarity_invert);
  endproperty
  a_cmp_high: assert property (p_cmp_high) else $error("output not high on match"); // RULE14

  property p_full_duty;
    is_pwm && st_r.output_function_sel == ctim_pkg::IO_PWM &&
      st_r.timer_on && !avs_write && duty_len >= per_len && !st_r.duty_period_swap
      |=> timer_output == ($past(st_r.output_initial_level) ^ $past(st_r.output_polarity_invert));
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty not active"); // RULE20

  property p_rd_high;
    avs_read && avs_address == ctim_pkg::OFS_CNT_HI && st_r.waitreq
      |=> !avs_waitrequest && avs_readdata[31:2] == 30'h0;
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("count high upper bits set"); // RULE8

  // compare output code checks leave out bus writes, which may restart the output
  property p_on_level;
    !st_r.timer_on ##1 st_r.timer_on |-> st_r.out_level == $past(st_r.output_initial_level);
  endproperty
  a_on_level: assert property (p_on_level) else $error("initial level not loaded"); // RULE15

  property p_cmp_low;
    st_r.timer_on && !is_pwm && a_hit && st_r.output_function_sel == ctim_pkg::IO_LOW &&
      !avs_write |=> !st_r.out_level;
  endproperty
  a_cmp_low: assert property (p_cmp_low) else $error("output not low on match"); // RULE22

  property p_cmp_toggle;
    st_r.timer_on && !is_pwm && a_hit && st_r.output_function_sel == ctim_pkg::IO_TOGGLE &&
      !avs_write |=> st_r.out_level != $past(st_r.out_level);
  endproperty
  a_cmp_toggle: assert property (p_cmp_toggle) else $error("output did not toggle"); // RULE22

  property p_cmp_none;
    !is_pwm && st_r.output_function_sel == ctim_pkg::IO_NONE && !avs_write
      |=> $stable(st_r.out_level);
  endproperty
  a_cmp_none: assert property (p_cmp_none) else $error("output changed"); // RULE14

  property p_pwm_inactive;
    is_pwm && st_r.output_function_sel == ctim_pkg::IO_INACTIVE
      |=> timer_output ==
          ($past(st_r.output_initial_level) ~^ $past(st_r.output_polarity_invert));
  endproperty
  a_pwm_inactive: assert property (p_pwm_inactive) else $error("not inactive"); // RULE23

  property p_pwm_active;
    is_pwm && st_r.output_function_sel == ctim_pkg::IO_ACTIVE
      |=> timer_output ==
          ($past(st_r.output_initial_level) ^ $past(st_r.output_polarity_invert));
  endproperty
  a_pwm_active: assert property (p_pwm_active) else $error("not active"); // RULE23

  property p_zero_cmp;
    st_r.compare_value == 10'h000 && !st_r.compare_match_flag && !avs_write
      |=> !st_r.compare_match_flag;
  endproperty
  a_zero_cmp: assert property (p_zero_cmp) else $error("flag from zero compare"); // RULE13

  property p_cnt_low;
    avs_read && avs_address == ctim_pkg::OFS_CNT_LO && st_r.waitreq
      |=> avs_readdata == {24'h000000, $past(st_r.counter[7:0])};
  endproperty
  a_cnt_low: assert property (p_cnt_low) else $error("count low byte wrong"); // RULE8

  property p_cnt_wrap;
    st_r.timer_on && st_r.counter == 10'h3FF && !avs_write |=> st_r.counter == 10'h000;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter did not wrap"); // RULE26

  property p_pwm_period;
    is_pwm && st_r.timer_on && st_r.counter_clear_source && !st_r.duty_period_swap &&
      p_hit && !avs_write |=> st_r.counter == 10'h000;
  endproperty
  a_pwm_period: assert property (p_pwm_period) else $error("pwm period clear missed"); // RULE7

  c_pwm_run: cover property (is_pwm && st_r.timer_on && p_hit);
  c_cmp_toggle: cover property (!is_pwm && a_hit &&
    st_r.output_function_sel == ctim_pkg::IO_TOGGLE);
  c_overflow: cover property (st_r.timer_on && st_r.counter == 10'h3FF ##1
    st_r.counter == 10'h000);
  c_write: cover property (avs_write && !avs_waitrequest);

endmodule

// file: hdl/ctim_pkg.sv
package ctim_pkg;

  // ----------------------------------------------------------------
  // register byte offsets (one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL0 = 5'h00;
  localparam logic [4:0] OFS_CTRL1 = 5'h04;
  localparam logic [4:0] OFS_CNT_LO = 5'h08;
  localparam logic [4:0] OFS_CNT_HI = 5'h0C;
  localparam logic [4:0] OFS_CMP_LO = 5'h10;
  localparam logic [4:0] OFS_CMP_HI = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ON_BIT = 3;
  localparam int PER_LSB = 0;
  localparam int MODE_LSB = 6;
  localparam int IOSEL_LSB = 4;
  localparam int OC_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int DPX_BIT = 1;
  localparam int CCLR_BIT = 0;
  localparam int FA_BIT = 0;
  localparam int FP_BIT = 1;
  localparam int OUT_BIT = 2;

  // ----------------------------------------------------------------
  // reset values and counter constants
  // ----------------------------------------------------------------
  localparam logic [9:0] RST_COUNT = 10'h000;
  localparam logic [9:0] RST_COMPARE = 10'h000;
  localparam logic [2:0] RST_PERIOD = 3'h0;
  localparam logic [10:0] FULL_SCALE = 11'h400;
  localparam logic [6:0] PERIOD_LOW_ZERO = 7'h00;

  // ----------------------------------------------------------------
  // modes and output function codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_CMP = 2'h0,
    MODE_UNDEF = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TC = 2'h3
  } ctim_mode_type;

  localparam logic [1:0] IO_NONE = 2'h0;
  localparam logic [1:0] IO_LOW = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TOGGLE = 2'h3;
  localparam logic [1:0] IO_INACTIVE = 2'h0;
  localparam logic [1:0] IO_ACTIVE = 2'h1;
  localparam logic [1:0] IO_PWM = 2'h2;

endpackage

// file: test/ctim_timer_test.sv
module ctim_timer_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk;
  logic rst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic timer_output;
  int n_errors;
  int checks;
  int hi;
  int per;
  logic [31:0] q;
  logic [31:0] q2;

  ctim_timer dut (
    .core_clk(core_clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .timer_output(timer_output)
  );

  // ----------------------------------------------------------------
  // clock, compare and bus tasks
  // ----------------------------------------------------------------
  // 50 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask

  // request held until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) chk("bus", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, q2);
  endtask

  task automatic rd(input string w, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00, q);
    chk(w, q, e);
  endtask

  // control1 byte: mode, output function, then oc/pol/swap/clear bits
  function automatic logic [7:0] cf(input logic [1:0] m, input logic [1:0] io,
                                    input logic [3:0] b);
    return {m, io, b};
  endfunction

  // mode and output function only change while the timer is off
  task automatic setup(input logic [7:0] c, input logic [9:0] v, input logic [2:0] p);
    wr(ctim_pkg::OFS_CTRL0, 8'h00);
    wr(ctim_pkg::OFS_CTRL1, c);
    wr(ctim_pkg::OFS_CMP_LO, v[7:0]);
    wr(ctim_pkg::OFS_CMP_HI, {6'h00, v[9:8]});
    wr(ctim_pkg::OFS_STATUS, 8'h03);
    wr(ctim_pkg::OFS_CTRL0, {4'h0, 1'b1, p});
  endtask

  // status just after start, then again after w cycles
  task automatic run(input logic [7:0] c, input logic [9:0] v, input logic [2:0] p,
                     input logic [31:0] s0, input logic [31:0] s1, input int w);
    setup(c, v, p);
    rd("stat0", ctim_pkg::OFS_STATUS, s0);
    repeat (w) @(posedge core_clk);
    rd("stat1", ctim_pkg::OFS_STATUS, s1);
  endtask

  // high time and period of the pin, sampled on the falling edge
  task automatic meas(output int h, output int p);
    int n;
    n = 0;
    h = 0;
    p = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (timer_output !== 1'b0 && n < 3000);
    do begin
      @(negedge core_clk);
      n++;
    end while (timer_output !== 1'b1 && n < 6000);
    while (timer_output === 1'b1 && p < 3000) begin
      @(negedge core_clk);
      h++;
      p++;
    end
    while (timer_output !== 1'b1 && p < 3000) begin
      @(negedge core_clk);
      p++;
    end
  endtask

  task automatic wave(input logic [7:0] c, input logic [9:0] v, input logic [2:0] p,
                      input int eh, input int ep, input logic [31:0] f);
    setup(c, v, p);
    meas(hi, per);
    chk("high", hi, eh);
    chk("period", per, ep);
    bus(1'b0, ctim_pkg::OFS_STATUS, 8'h00, q);
    chk("flags", q & 32'h3, f);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  // watchdog: the whole run needs well under 20000 cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    n_errors++;
    results();
  end

  initial begin
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    n_errors = 0;
    checks = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    // reset values, read-only count, unimplemented bits, unmapped place
    rd("cnt_lo", ctim_pkg::OFS_CNT_LO, 32'h0);
    rd("cnt_hi", ctim_pkg::OFS_CNT_HI, 32'h0);
    rd("cmp_lo", ctim_pkg::OFS_CMP_LO, 32'h0);
    rd("cmp_hi", ctim_pkg::OFS_CMP_HI, 32'h0);
    wr(ctim_pkg::OFS_CMP_HI, 8'hFF);
    wr(ctim_pkg::OFS_CMP_LO, 8'hA5);
    wr(ctim_pkg::OFS_CNT_LO, 8'h5A);
    rd("cmp_hi", ctim_pkg::OFS_CMP_HI, 32'h3);
    rd("cmp_lo", ctim_pkg::OFS_CMP_LO, 32'hA5);
    rd("cnt_ro", ctim_pkg::OFS_CNT_LO, 32'h0);
    rd("unmapped", 5'h1C, 32'h0);
    $display("test registers done");
    // compare and timer modes: clearing, flags, output codes, initial level
    wave(cf(ctim_pkg::MODE_CMP, ctim_pkg::IO_TOGGLE, 4'h1),
         10'h0C8, 3'h1, 200, 400, 32'h1);
    run(cf(ctim_pkg::MODE_CMP, ctim_pkg::IO_NONE, 4'h8),
        10'h00A, 3'h1, 32'h4, 32'h7, 300);
    run(cf(ctim_pkg::MODE_CMP, ctim_pkg::IO_LOW, 4'h8),
        10'h00A, 3'h1, 32'h4, 32'h3, 300);
    run(cf(ctim_pkg::MODE_CMP, ctim_pkg::IO_HIGH, 4'h0),
        10'h00A, 3'h1, 32'h0, 32'h7, 300);
    run(cf(ctim_pkg::MODE_TC, ctim_pkg::IO_HIGH, 4'hC),
        10'h00A, 3'h1, 32'h0, 32'h3, 300);
    run(cf(ctim_pkg::MODE_CMP, ctim_pkg::IO_NONE, 4'h0),
        10'h3E8, 3'h0, 32'h0, 32'h3, 1100);
    run(cf(ctim_pkg::MODE_CMP, ctim_pkg::IO_NONE, 4'h0),
        10'h300, 3'h2, 32'h0, 32'h2, 600);
    run(cf(ctim_pkg::MODE_CMP, ctim_pkg::IO_HIGH, 4'h1),
        10'h000, 3'h1, 32'h0, 32'h0, 1100);
    $display("test compare done");
    // pwm mode, clear-source bit set throughout to show it is ignored
    wave(cf(ctim_pkg::MODE_PWM, ctim_pkg::IO_PWM, 4'h9),
         10'h020, 3'h1, 32, 128, 32'h3);
    wave(cf(ctim_pkg::MODE_PWM, ctim_pkg::IO_PWM, 4'h1),
         10'h020, 3'h1, 96, 128, 32'h3);
    wave(cf(ctim_pkg::MODE_PWM, ctim_pkg::IO_PWM, 4'hD),
         10'h020, 3'h1, 96, 128, 32'h3);
    wave(cf(ctim_pkg::MODE_PWM, ctim_pkg::IO_PWM, 4'hB),
         10'h0C8, 3'h1, 128, 200, 32'h3);
    run(cf(ctim_pkg::MODE_PWM, ctim_pkg::IO_INACTIVE, 4'h9),
        10'h020, 3'h1, 32'h0, 32'h3, 300);
    run(cf(ctim_pkg::MODE_PWM, ctim_pkg::IO_ACTIVE, 4'h9),
        10'h020, 3'h1, 32'h4, 32'h7, 300);
    setup(cf(ctim_pkg::MODE_PWM, ctim_pkg::IO_PWM, 4'h9), 10'h12C, 3'h1);
    hi = 0;
    repeat (300) begin
      @(negedge core_clk);
      if (timer_output !== 1'b1) hi++;
    end
    chk("full", hi, 0);
    $display("test pwm done");
    // stop keeps the residual count, restart clears it
    setup(cf(ctim_pkg::MODE_CMP, ctim_pkg::IO_NONE, 4'h0), 10'h000, 3'h0);
    repeat (600) @(posedge core_clk);
    wr(ctim_pkg::OFS_CTRL0, 8'h00);
    repeat (300) @(posedge core_clk);
    rd("hold", ctim_pkg::OFS_CNT_HI, 32'h2);
    wr(ctim_pkg::OFS_CTRL0, 8'h08);
    rd("restart", ctim_pkg::OFS_CNT_HI, 32'h0);
    $display("test on off done");
    results();
  end
endmodule
